// >>> logic/psam_pkg.sv
// constants of the pixel to sdram address map block
`default_nettype none
package psam_pkg;
   // =====================================================================
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_PIX_X       = 8'h04;
   localparam logic [7:0]  OFS_PIX_Y       = 8'h08;
   localparam logic [7:0]  OFS_LAYER       = 8'h0c;
   localparam logic [7:0]  OFS_RESULT      = 8'h10;
   localparam logic [7:0]  OFS_STATUS      = 8'h14;
   localparam logic [7:0]  OFS_DELAY_CFG   = 8'h18;
   localparam logic [7:0]  OFS_WIN_OFS     = 8'h1c;
   localparam logic [7:0]  OFS_WIN_SDRAM   = 8'h20;
   localparam logic [7:0]  OFS_WIN_SIZE    = 8'h24;
   localparam logic [7:0]  OFS_CS_BASE     = 8'h28;
   localparam logic [7:0]  OFS_FIELDS      = 8'h2c;
   localparam logic [7:0]  OFS_SDRAM_ADDR  = 8'h30;
   localparam logic [1:0]  TBL_START       = 2'h1;
   localparam logic [1:0]  TBL_WIDTH       = 2'h2;
   localparam logic [1:0]  TBL_FMT         = 2'h3;
   // =====================================================================
   // field positions
   localparam int          CTRL_START_BIT  = 0;
   localparam int          CTRL_HOST_BIT   = 1;
   localparam int          STAT_DONE_BIT   = 0;
   localparam int          STAT_OUTWIN_BIT = 1;
   localparam int          DLY_ADDR_LSB    = 6;
   localparam int          DLY_WDATA_LSB   = 4;
   localparam int          DLY_RDATA_LSB   = 2;
   localparam int          DLY_OE_LSB      = 0;
   localparam logic [31:0] START_MASK_4B   = 32'h007ff000;
   localparam logic [31:0] START_MASK_1B   = 32'h000ffc00;
   // =====================================================================
   // reset values
   localparam logic [7:0]  DELAY_CFG_RST   = 8'h00;
   localparam logic [31:0] CS_BASE_RST     = 32'h00000000;
   // =====================================================================
   // colour format codes
   localparam logic [3:0]  FMT_1BPP        = 4'h0;
   localparam logic [3:0]  FMT_2BPP        = 4'h1;
   localparam logic [3:0]  FMT_4BPP        = 4'h2;
   localparam logic [3:0]  FMT_8BPP        = 4'h3;
   localparam logic [3:0]  FMT_RGB555      = 4'h4;
   localparam logic [3:0]  FMT_RGB565      = 4'h5;
   localparam logic [3:0]  FMT_YUV422      = 4'h7;
   localparam logic [3:0]  FMT_YUV555      = 4'he;
   localparam logic [3:0]  FMT_YUV655      = 4'hf;
   // =====================================================================
   // tap delays: setting n picks tap of (n + 1) ns nominal
   localparam int          TAP_STEP_NS     = 1;
   localparam int          TAP_COUNT       = 4;
endpackage
`default_nettype wire

// >>> logic/psam_addr_map.sv
// combinational pixel coordinate to sdram and bus address conversion
`timescale 1ns/1ns
`default_nettype none
module psam_addr_map #(
   parameter bit FOUR_BANK = 1'b1
) (
   input  wire logic [13:0] pix_x,
   input  wire logic [13:0] pix_y,
   input  wire logic [13:0] width,
   input  wire logic [3:0]  fmt,
   input  wire logic [31:0] start,
   input  wire logic [31:0] cs_base,
   input  wire logic [31:0] win_ofs,
   input  wire logic [31:0] win_sd,
   input  wire logic        host_mode,
   output logic      [18:0] pix_off,
   output logic      [11:0] row_blocks,
   output logic      [20:0] row_addr,
   output logic      [1:0]  bank,
   output logic      [7:0]  col,
   output logic      [31:0] sdram_byte,
   output logic      [31:0] phys_addr,
   output logic      [31:0] access_addr
);
   logic [2:0]  shift;
   logic [18:0] line_bits;

   // =====================================================================
   // bits per pixel as a shift
   always_comb begin
      unique case (fmt)
         psam_pkg::FMT_1BPP:   shift = 3'h0;
         psam_pkg::FMT_2BPP:   shift = 3'h1;
         psam_pkg::FMT_4BPP:   shift = 3'h2;
         psam_pkg::FMT_8BPP:   shift = 3'h3;
         psam_pkg::FMT_RGB555,
         psam_pkg::FMT_RGB565,
         psam_pkg::FMT_YUV422,
         psam_pkg::FMT_YUV555,
         psam_pkg::FMT_YUV655: shift = 3'h4;
         default:              shift = 3'h5;
      endcase
   end

   assign line_bits = {5'h0, width} << shift;
   assign pix_off   = {5'h0, pix_x} << shift;
   assign col       = {pix_y[4:0], pix_off[7:5]};

   // =====================================================================
   // row block geometry per variant
   always_comb begin
      if (FOUR_BANK) begin
         // 16 words by 64 lines per block
         row_blocks = {2'h0, line_bits[18:9]}
                    + {11'h0, |line_bits[8:0]};
         row_addr   = 21'(pix_y[13:6] * row_blocks)
                    + {11'h0, pix_off[18:9]};
         bank       = {pix_y[5], pix_off[8]};
         sdram_byte = {row_addr[19:0], bank, col, 2'b00};
      end else begin
         // 8 words by 32 lines, single bank
         row_blocks = {1'b0, line_bits[18:8]} + {11'h0, |line_bits[7:0]};
         row_addr   = 21'(pix_y[13:5] * row_blocks)
                    + {10'h0, pix_off[18:8]};
         bank       = 2'b00;
         sdram_byte = {1'b0, row_addr, col, 2'b00};
      end
   end

   assign phys_addr   = start + sdram_byte;
   assign access_addr = host_mode ? phys_addr + cs_base + win_ofs - win_sd
                                  : phys_addr;
endmodule // psam_addr_map
`default_nettype wire

// >>> logic/psam_tap_sel.sv
// per group delay tap selection for the sdram pad clock chains
`timescale 1ns/1ns
`default_nettype none
module psam_tap_sel (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  delay_cfg,
   output logic      [15:0] tap_sel
);
   localparam int LSB[4] = '{psam_pkg::DLY_OE_LSB, psam_pkg::DLY_RDATA_LSB,
                             psam_pkg::DLY_WDATA_LSB, psam_pkg::DLY_ADDR_LSB};

   // =====================================================================
   // one-hot tap mux select; group g sits in tap_sel[4g+3:4g]
   genvar g;
   for (g = 0; g < 4; g++) begin : g_grp
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            tap_sel[4*g +: 4] <= 4'h1;
         end else begin
            tap_sel[4*g +: 4] <= 4'h1 << delay_cfg[LSB[g] +: 2];
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_tap_onehot;
      ##1 $onehot(tap_sel[15:12]) && $onehot(tap_sel[3:0]);
   endproperty
   a_tap_onehot: assert property (p_tap_onehot)
      else $error("tap select not one-hot");

   property p_tap_field;
      ##1 tap_sel[15:12] == 4'h1 << $past(delay_cfg[7:6])
         && tap_sel[11:8] == 4'h1 << $past(delay_cfg[5:4])
         && tap_sel[7:4] == 4'h1 << $past(delay_cfg[3:2])
         && tap_sel[3:0] == 4'h1 << $past(delay_cfg[1:0]);
   endproperty
   a_tap_field: assert property (p_tap_field)
      else $error("tap select does not follow its config field");
endmodule // psam_tap_sel
`default_nettype wire

// >>> logic/psam_top.sv
// pixel to sdram address map with avalon register slave and pad delay taps
// Function
// - four-bank row blocks per line = line bits [18:9] plus one if [8:0] set
// - row address = Y[13:6] times row blocks plus pixel offset [18:9]
// - bank = {Y[5], pixel offset bit 8}
// - column = {Y[4:0], pixel offset [7:5]}, eight bits
// - byte address = {row, bank, column, 2'b00}
// - add the layer start offset to get the physical address
// - internal use as is; host adds chip base plus window minus sdram offset
// - single bank uses 8x32 blocks, four bank 16x64 blocks
// - four delay groups: address/command, write data, read sample, enable
// - each group picks one tap via a two-bit field of one byte
// - taps span about 1ns to 4ns in 1ns steps, rising with setting
// - single bank integrated variant has no delay logic
// - fields: address [7:6], write [5:4], read [3:2], enable [1:0]
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module psam_top #(
   parameter bit FOUR_BANK = 1'b1
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RESET_N,
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic      [31:0] PIX_ADDR,
   output logic             PIX_ADDR_VALID,
   output logic      [15:0] SDRAM_TAP_SEL
);
   // =====================================================================
   // declarations
   logic [31:0] layer_start_offset [16];
   logic [13:0] layer_width_pixels [16];
   logic [3:0]  layer_color_format [16];
   logic [13:0] pix_x_q;
   logic [13:0] pix_y_q;
   logic [3:0]  layer_q;
   logic        host_mode_q;
   logic        start_q;
   logic        done_q;
   logic        out_win_q;
   logic [7:0]  delay_cfg_q;
   logic [31:0] host_window_offset_q;
   logic [31:0] window_sdram_offset_q;
   logic [31:0] window_size_q;
   logic [31:0] cs_base_q;
   logic [31:0] result_q;
   logic [31:0] sdram_q;
   logic [20:0] ra_q;
   logic [1:0]  ba_q;
   logic [7:0]  ca_q;
   logic        wait_q;
   logic [31:0] rdata_d;
   logic        acc_rd;
   logic        acc_wr;
   logic [31:0] wmask;
   logic [18:0] pix_off;
   logic [11:0] row_blocks;
   logic [20:0] row_addr;
   logic [1:0]  bank;
   logic [7:0]  col;
   logic [31:0] sdram_byte;
   logic [31:0] phys_addr;
   logic [31:0] access_addr;
   logic [31:0] start_mask;

   // =====================================================================
   // avalon slave handshake: one wait state, then the access completes
   assign acc_rd = AVS_READ && !wait_q;
   assign acc_wr = AVS_WRITE && !wait_q;
   assign wmask  = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
   assign start_mask = FOUR_BANK ? psam_pkg::START_MASK_4B
                                 : psam_pkg::START_MASK_1B;

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wait_q <= 1'b1;
      end else if ((AVS_READ || AVS_WRITE) && wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end
   assign AVS_WAITREQUEST = wait_q;

   // =====================================================================
   // read mux, captured in the wait cycle so data stand with the release
   always_comb begin
      rdata_d = 32'h0;
      if (AVS_ADDRESS[7:6] != 2'h0) begin
         unique case (AVS_ADDRESS[7:6])
            psam_pkg::TBL_START:
               rdata_d = layer_start_offset[AVS_ADDRESS[5:2]];
            psam_pkg::TBL_WIDTH:
               rdata_d = {18'h0, layer_width_pixels[AVS_ADDRESS[5:2]]};
            default:
               rdata_d = {28'h0, layer_color_format[AVS_ADDRESS[5:2]]};
         endcase
      end else begin
         case ({AVS_ADDRESS[7:2], 2'b00})
            psam_pkg::OFS_CTRL:      rdata_d = {30'h0, host_mode_q, 1'b0};
            psam_pkg::OFS_PIX_X:     rdata_d = {18'h0, pix_x_q};
            psam_pkg::OFS_PIX_Y:     rdata_d = {18'h0, pix_y_q};
            psam_pkg::OFS_LAYER:     rdata_d = {28'h0, layer_q};
            psam_pkg::OFS_RESULT:    rdata_d = result_q;
            psam_pkg::OFS_STATUS:    rdata_d = {30'h0, out_win_q, done_q};
            psam_pkg::OFS_DELAY_CFG: rdata_d = {24'h0, delay_cfg_q};
            psam_pkg::OFS_WIN_OFS:   rdata_d = host_window_offset_q;
            psam_pkg::OFS_WIN_SDRAM: rdata_d = window_sdram_offset_q;
            psam_pkg::OFS_WIN_SIZE:  rdata_d = window_size_q;
            psam_pkg::OFS_CS_BASE:   rdata_d = cs_base_q;
            psam_pkg::OFS_FIELDS:
               rdata_d = {ra_q, ba_q, ca_q, 1'b0};
            psam_pkg::OFS_SDRAM_ADDR: rdata_d = sdram_q;
            default:                 rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         AVS_READDATA <= 32'h0;
      end else if (AVS_READ && wait_q) begin
         AVS_READDATA <= rdata_d;
      end
   end

   // =====================================================================
   // layer tables, one entry per layer
   genvar i;
   for (i = 0; i < 16; i++) begin : g_layer
      always_ff @(posedge CORE_CLK or negedge RESET_N) begin
         if (!RESET_N) begin
            layer_start_offset[i] <= 32'h0;
            layer_width_pixels[i] <= 14'h0;
            layer_color_format[i] <= 4'h0;
         end else if (acc_wr && AVS_ADDRESS[5:2] == 4'(i)) begin
            // only the row bits of a start offset are kept
            if (AVS_ADDRESS[7:6] == psam_pkg::TBL_START) begin
               layer_start_offset[i] <= ((layer_start_offset[i] & ~wmask)
                  | (AVS_WRITEDATA & wmask)) & start_mask;
            end
            if (AVS_ADDRESS[7:6] == psam_pkg::TBL_WIDTH) begin
               layer_width_pixels[i] <= 14'((layer_width_pixels[i]
                  & ~wmask[13:0]) | (AVS_WRITEDATA[13:0] & wmask[13:0]));
            end
            if (AVS_ADDRESS[7:6] == psam_pkg::TBL_FMT && AVS_BYTEENABLE[0]) begin
               layer_color_format[i] <= AVS_WRITEDATA[3:0];
            end
         end
      end
   end

   // =====================================================================
   // request and window registers
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pix_x_q               <= 14'h0;
         pix_y_q               <= 14'h0;
         layer_q               <= 4'h0;
         host_mode_q           <= 1'b0;
         delay_cfg_q           <= psam_pkg::DELAY_CFG_RST;
         host_window_offset_q  <= 32'h0;
         window_sdram_offset_q <= 32'h0;
         window_size_q         <= 32'h0;
         cs_base_q             <= psam_pkg::CS_BASE_RST;
      end else if (acc_wr && AVS_ADDRESS[7:6] == 2'h0) begin
         case ({AVS_ADDRESS[7:2], 2'b00})
            psam_pkg::OFS_CTRL: begin
               if (AVS_BYTEENABLE[0]) begin
                  host_mode_q <= AVS_WRITEDATA[psam_pkg::CTRL_HOST_BIT];
               end
            end
            psam_pkg::OFS_PIX_X: begin
               pix_x_q <= 14'((pix_x_q & ~wmask[13:0])
                  | (AVS_WRITEDATA[13:0] & wmask[13:0]));
            end
            psam_pkg::OFS_PIX_Y: begin
               pix_y_q <= 14'((pix_y_q & ~wmask[13:0])
                  | (AVS_WRITEDATA[13:0] & wmask[13:0]));
            end
            psam_pkg::OFS_LAYER: begin
               if (AVS_BYTEENABLE[0]) begin
                  layer_q <= AVS_WRITEDATA[3:0];
               end
            end
            psam_pkg::OFS_DELAY_CFG: begin
               if (AVS_BYTEENABLE[0]) begin
                  delay_cfg_q <= AVS_WRITEDATA[7:0];
               end
            end
            psam_pkg::OFS_WIN_OFS: begin
               host_window_offset_q <= (host_window_offset_q & ~wmask)
                  | (AVS_WRITEDATA & wmask);
            end
            psam_pkg::OFS_WIN_SDRAM: begin
               window_sdram_offset_q <= (window_sdram_offset_q & ~wmask)
                  | (AVS_WRITEDATA & wmask);
            end
            psam_pkg::OFS_WIN_SIZE: begin
               window_size_q <= (window_size_q & ~wmask)
                  | (AVS_WRITEDATA & wmask);
            end
            psam_pkg::OFS_CS_BASE: begin
               cs_base_q <= (cs_base_q & ~wmask) | (AVS_WRITEDATA & wmask);
            end
            default: begin
            end
         endcase
      end
   end

   // start pulse from a control write
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         start_q <= 1'b0;
      end else begin
         start_q <= acc_wr && {AVS_ADDRESS[7:2], 2'b00} == psam_pkg::OFS_CTRL
                    && AVS_BYTEENABLE[0]
                    && AVS_WRITEDATA[psam_pkg::CTRL_START_BIT];
      end
   end

   // =====================================================================
   // conversion datapath
   psam_addr_map #(
      .FOUR_BANK (FOUR_BANK)
   ) u_map (
      .pix_x       (pix_x_q),
      .pix_y       (pix_y_q),
      .width       (layer_width_pixels[layer_q]),
      .fmt         (layer_color_format[layer_q]),
      .start       (layer_start_offset[layer_q]),
      .cs_base     (cs_base_q),
      .win_ofs     (host_window_offset_q),
      .win_sd      (window_sdram_offset_q),
      .host_mode   (host_mode_q),
      .pix_off     (pix_off),
      .row_blocks  (row_blocks),
      .row_addr    (row_addr),
      .bank        (bank),
      .col         (col),
      .sdram_byte  (sdram_byte),
      .phys_addr   (phys_addr),
      .access_addr (access_addr)
   );

   // result capture; a new start clears done, the capture edge sets it
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         result_q  <= 32'h0;
         sdram_q   <= 32'h0;
         ra_q      <= 21'h0;
         ba_q      <= 2'h0;
         ca_q      <= 8'h0;
         done_q    <= 1'b0;
         out_win_q <= 1'b0;
      end else if (start_q) begin
         result_q  <= access_addr;
         sdram_q   <= sdram_byte;
         ra_q      <= row_addr;
         ba_q      <= bank;
         ca_q      <= col;
         done_q    <= 1'b1;
         // host view only reaches pixels inside the mapped window
         out_win_q <= host_mode_q && (phys_addr < window_sdram_offset_q
            || phys_addr >= window_sdram_offset_q + window_size_q);
      end else if (acc_wr && {AVS_ADDRESS[7:2], 2'b00} == psam_pkg::OFS_CTRL
                   && AVS_BYTEENABLE[0]
                   && AVS_WRITEDATA[psam_pkg::CTRL_START_BIT]) begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PIX_ADDR       <= 32'h0;
         PIX_ADDR_VALID <= 1'b0;
      end else begin
         PIX_ADDR_VALID <= start_q;
         if (start_q) begin
            PIX_ADDR <= access_addr;
         end
      end
   end

   // =====================================================================
   // pad delay taps exist only with the external port
   if (FOUR_BANK) begin : g_taps
      psam_tap_sel u_taps (
         .clk       (CORE_CLK),
         .rst_n     (RESET_N),
         .delay_cfg (delay_cfg_q),
         .tap_sel   (SDRAM_TAP_SEL)
      );
   end else begin : g_no_taps
      always_ff @(posedge CORE_CLK or negedge RESET_N) begin
         if (!RESET_N) begin
            SDRAM_TAP_SEL <= 16'h0;
         end else begin
            SDRAM_TAP_SEL <= 16'h0;
         end
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   sequence s_start;
      start_q;
   endsequence

   sequence s_done;
      done_q && PIX_ADDR_VALID;
   endsequence

   property p_result;
      s_start |=> s_done and (result_q == $past(access_addr)
         && PIX_ADDR == result_q);
   endproperty
   a_result: assert property (p_result)
      else $error("result not captured after start");

   property p_host;
      s_start ##1 !$past(host_mode_q) |-> result_q == sdram_q
         + $past(layer_start_offset[layer_q]);
   endproperty
   a_host: assert property (p_host)
      else $error("internal access address not the physical address");

   property p_bank;
      s_start |=> ba_q == (FOUR_BANK ? {$past(pix_y_q[5]), $past(pix_off[8])}
                                     : 2'b00);
   endproperty
   a_bank: assert property (p_bank)
      else $error("bank bits wrong");

   property p_col;
      s_start |=> ca_q == {$past(pix_y_q[4:0]), $past(pix_off[7:5])};
   endproperty
   a_col: assert property (p_col)
      else $error("column bits wrong");

   property p_row;
      FOUR_BANK && start_q |-> row_addr == 21'(pix_y_q[13:6] * row_blocks)
         + {11'h0, pix_off[18:9]};
   endproperty
   a_row: assert property (p_row)
      else $error("row address wrong");

   property p_concat;
      done_q && FOUR_BANK |-> sdram_q == {ra_q[19:0], ba_q, ca_q, 2'b00};
   endproperty
   a_concat: assert property (p_concat)
      else $error("sdram byte address not row bank column");

   property p_bpp;
      start_q && layer_color_format[layer_q] == psam_pkg::FMT_RGB555
         |-> pix_off == {1'b0, pix_x_q, 4'h0};
   endproperty
   a_bpp: assert property (p_bpp)
      else $error("16 bpp pixel offset wrong");

   property p_blocks;
      start_q && FOUR_BANK && pix_off == 19'h0 && pix_y_q[13:6] == 8'h1
         |-> row_addr == {9'h0, row_blocks};
   endproperty
   a_blocks: assert property (p_blocks)
      else $error("row block count not applied");

   property p_wait;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST
         ##1 AVS_WAITREQUEST;
   endproperty
   a_wait: assert property (p_wait)
      else $error("bus answer not after one wait state");
endmodule // psam_top
`default_nettype wire

// >>> tb/psam_sdram_model.sv
// far side model: reads back the sample delay picked by the tap selects
`timescale 1ns/1ns
`default_nettype none
module psam_sdram_model (
   input  wire logic [15:0] tap_sel,
   output logic      [2:0]  rs_ns
);
   // =====================================================================
   // one-hot tap n of the read group means (n + 1) ns
   always_comb begin
      rs_ns = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (tap_sel[4+i]) rs_ns = 3'(i + 1);
      end
   end
endmodule // psam_sdram_model
`default_nettype wire

// >>> tb/pixel_sdram_address_map_tb_top.sv
// self-checking bench of the pixel to sdram address map block
`timescale 1ns/1ns
`default_nettype none
module pixel_sdram_address_map_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat, pa, q;
   logic        wreq, pv;
   logic [15:0] taps;
   logic [2:0]  rs_ns;
   int          err_count = 0;
   int          checks_done = 0;
   int          cyc = 0;
   logic [3:0]  fm [10] = '{0, 1, 2, 3, 4, 5, 7, 14, 15, 6};
   int          bp [10] = '{1, 2, 4, 8, 16, 16, 16, 16, 16, 32};
   int          o;
   psam_top dut (.CORE_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
      .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wreq), .PIX_ADDR(pa), .PIX_ADDR_VALID(pv),
      .SDRAM_TAP_SEL(taps));
   psam_sdram_model far (.tap_sel(taps), .rs_ns(rs_ns));
   always #4 clk = ~clk;
   // =====================================================================
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd   <= d;
      wr   <= w;
      rd   <= ~w;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic conv(input logic [31:0] x, input logic [31:0] y,
                       input logic [31:0] c);
      bus(1'b1, 8'h04, x);
      bus(1'b1, 8'h08, y);
      bus(1'b1, 8'h00, c);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(32'(taps), 32'h1111);
      rchk(8'h18, 32'h0);
      bus(1'b1, 8'h40, 32'h20000);
      bus(1'b1, 8'h80, 32'd640);
      bus(1'b1, 8'hc0, 32'h4);
      bus(1'b1, 8'h0c, 32'h0);
      conv(32'd115, 32'd250, 32'h1);
      repeat (2) @(posedge clk);
      chk(32'(pv), 32'h1);
      rchk(8'h14, 32'h1);
      rchk(8'h30, 32'h3ff44);
      rchk(8'h2c, 32'h1ffa2);
      rchk(8'h10, 32'h5ff44);
      chk(pa, 32'h5ff44);
      bus(1'b1, 8'h28, 32'h30000000);
      bus(1'b1, 8'h1c, 32'h40000);
      bus(1'b1, 8'h24, 32'h80000);
      bus(1'b1, 8'h20, 32'h0);
      bus(1'b1, 8'h00, 32'h3);
      rchk(8'h10, 32'h3009ff44);
      bus(1'b1, 8'h24, 32'h40000);
      bus(1'b1, 8'h00, 32'h3);
      rchk(8'h14, 32'h3);
      bus(1'b1, 8'h80, 32'd641);
      conv(32'd0, 32'd64, 32'h1);
      rchk(8'h30, 32'h15000);
      for (int i = 0; i < 10; i++) begin
         bus(1'b1, 8'hc0, 32'(fm[i]));
         conv(32'd16, 32'd0, 32'h1);
         o = 16 * bp[i];
         rchk(8'h30, ((o >> 9) << 12) | (((o >> 8) & 1) << 10)
                     | (((o >> 5) & 7) << 2));
      end
      bus(1'b1, 8'h18, 32'h58);
      repeat (2) @(posedge clk);
      chk(32'(taps), 32'h2241);
      chk(32'(rs_ns), 32'h3);
      rchk(8'h18, 32'h58);
      rchk(8'h34, 32'h0);
      stop_test();
   end
endmodule // pixel_sdram_address_map_tb_top
`default_nettype wire
